//--- hdl/lemc_top.sv
// Purpose: Billing tone, on-hook monitor and caller ID control with APB registers
// Assumes: Analog detectors arrive as synchronous levels; samples as 16-bit words
// Notes:   APB answers with one wait state; unmapped addresses give pslverr
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (R1) Billing detection acts only while enable set
// (R2) Low-pass filter removes small line tones
// (R3) Overload flag sets above 1.1 V peak
// (R4) Supply depletion sets detect, selects 800 ohm
// (R5) Both flags sticky until host writes zero
// (R6) Host polls overload, then clears enable
// (R7) Termination restores over about one second
// (R8) Host re-enables only after all cleared
// (R9) Host qualifies several events before trusting
// (R10) Hookswitch never dropped by billing events
// (R11) Monitor enable starts 450 uA converter
// (R12) Low-power select picks 7 uA converter
// (R13) Host clears monitor before going off-hook
// (R14) Gain field attenuates low-power converter input
// (R15) Host should prefer low-power converter
// (R16) Ring coupling reset bit resets ac coupling
// (R17) Host sets select before monitor enable
// (R18) Host holds coupling reset through data
// (R19) Host clears three bits before next ring
// (R20) Host enables full-wave ring detection first
// (R21) Host waits 40 ms to confirm reversal
// (R22) Host sets coupling reset, then monitor
// (R23) Converter samples leave on serial output
// (R24) Ring flags follow threshold comparators
// (R25) Writing one leaves sticky flags unchanged
module lemc_top
	import lemc_pkg::*;
#(
	parameter int unsigned RESTORE_CYCLES = RESTORE_CYC
) (
	input  wire logic              ref_clk,       // 50 MHz clock
	input  wire logic              rst_n,         // Async reset, active low
	input  wire logic [7:0]        paddr,         // APB address
	input  wire logic              psel,          // APB select
	input  wire logic              penable,       // APB enable
	input  wire logic              pwrite,        // APB direction
	input  wire logic [31:0]       pwdata,        // APB write data
	output logic [31:0]            prdata,        // APB read data
	output logic                   pready,        // APB ready
	output logic                   pslverr,       // APB error
	input  wire lemc_pkg::lemc_line_t line_in,    // Detector levels
	input  wire logic signed [15:0] rx_sample,    // Off-hook receive sample
	input  wire logic              rx_valid,      // Receive strobe
	input  wire logic [15:0]       hp_sample,     // 450 uA converter word
	input  wire logic [15:0]       lp_sample,     // 7 uA converter word
	input  wire logic              mon_valid,     // Converter strobe
	output logic                   hookswitch,    // Off-hook drive
	output logic                   term_800ohm,   // 800 ohm dc termination
	output logic                   dc_restore,    // Termination restoring
	output logic                   hp_adc_en,     // 450 uA converter on
	output logic                   lp_adc_en,     // 7 uA converter on
	output logic [2:0]             lp_atten,      // Converter attenuation step
	output logic                   ring_coupling_reset, // Ring ac coupling reset
	output logic signed [15:0]     rx_filtered,   // Filtered receive sample
	output logic                   rx_filt_valid, // Filtered strobe
	output logic                   serial_sample_out, // Serial sample bit
	output logic                   sample_frame   // Serial word start
);
	import lemc_pkg::*;

	lemc_ctrl_t     ctrl_reg, ctrl_next;
	logic           rov_reg, rov_next, btd_reg, btd_next;
	logic           rpos_reg, rneg_reg, hook_reg;
	logic           rdy_reg, rdy_next, err_reg, err_next;
	logic [31:0]    rd_reg, rd_next;
	lemc_term_t     term_reg, term_next;
	logic [RESTORE_W-1:0] cnt_reg, cnt_next;
	logic           hp_reg, lp_reg, rcr_reg;
	logic [2:0]     att_reg;
	logic [15:0]    word_reg, word_next;
	logic           load_reg, load_next;
	logic           ovl_level, wr_stat, wr_ctrl, done;
	logic           term800_reg, restore_reg;

	function automatic logic [31:0] stat_word(input logic receive_overload_flag, input logic billing_tone_detected_flag,
			input logic overload_level_indicator, input logic rp, input logic rn, input lemc_term_t t);
		stat_word            = '0;
		stat_word[STAT_ROV]  = receive_overload_flag;
		stat_word[STAT_BTD]  = billing_tone_detected_flag;
		stat_word[STAT_OVL]  = overload_level_indicator;
		stat_word[STAT_RPOS] = rp;
		stat_word[STAT_RNEG] = rn;
		stat_word[STAT_T800] = (t == TERM_800);
		stat_word[STAT_RAMP] = (t == TERM_RESTORE);
	endfunction : stat_word

	lemc_rx_filter u_filt (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.x       (rx_sample),
		.x_valid (rx_valid),
		.y       (rx_filtered),
		.y_valid (rx_filt_valid),
		.over    (ovl_level)
	);

	lemc_ser u_ser (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.word    (word_reg),
		.load    (load_reg),
		.sdata   (serial_sample_out),
		.frame   (sample_frame)
	);

	// APB slave: one wait state so read data comes from a flop
	always_comb begin
		done     = psel && penable && rdy_reg;
		wr_ctrl  = done && pwrite && paddr == ADDR_CTRL;
		wr_stat  = done && pwrite && paddr == ADDR_STAT;
		rdy_next = psel && penable && !rdy_reg;
		err_next = rdy_next && paddr != ADDR_CTRL && paddr != ADDR_STAT;
		rd_next  = rd_reg;
		if (rdy_next) begin
			unique case (paddr)
				ADDR_CTRL: rd_next = {24'h000000, ctrl_reg};
				ADDR_STAT: rd_next = stat_word(rov_reg, btd_reg, ovl_level,
					rpos_reg, rneg_reg, term_reg);
				default:   rd_next = 32'h00000000;
			endcase
		end
		ctrl_next = ctrl_reg;
		if (wr_ctrl)
			ctrl_next = lemc_ctrl_t'(pwdata[CTRL_W-1:0]);
	end

	// Sticky flags: a written zero clears, a written one keeps, a new event wins
	always_comb begin
		rov_next = rov_reg;
		btd_next = btd_reg;
		if (wr_stat && !pwdata[STAT_ROV])                  // R25
			rov_next = 1'b0;                                // R5
		if (wr_stat && !pwdata[STAT_BTD])                  // R25
			btd_next = 1'b0;                                // R5
		if (ctrl_reg.billing_tone_enable && ovl_level)                     // R1
			rov_next = 1'b1;                                // R3
		if (ctrl_reg.billing_tone_enable && line_in.supply_depleted)       // R1
			btd_next = 1'b1;                                // R4
	end

	// Termination: 800 ohm on detection, slow return once enable drops
	always_comb begin
		term_next = term_reg;
		cnt_next  = cnt_reg;
		unique case (term_reg)
			TERM_NORMAL:
				if (ctrl_reg.billing_tone_enable && line_in.supply_depleted)
					term_next = TERM_800;                       // R4
			TERM_800:
				if (!ctrl_reg.billing_tone_enable) begin
					term_next = TERM_RESTORE;                   // R7
					cnt_next  = RESTORE_W'(RESTORE_CYCLES - 1);
				end
			TERM_RESTORE:
				if (ctrl_reg.billing_tone_enable && line_in.supply_depleted)
					term_next = TERM_800;
				else if (cnt_reg == '0)
					term_next = TERM_NORMAL;                    // R7
				else
					cnt_next = cnt_reg - 1'b1;
			default:
				term_next = TERM_NORMAL;
		endcase
	end

	// Monitor word: converter samples while monitoring, ring code while on-hook otherwise
	always_comb begin
		word_next = word_reg;
		load_next = 1'b0;
		if (ctrl_reg.onhook_monitor_enable) begin
			load_next = mon_valid;
			if (mon_valid)
				word_next = ctrl_reg.lp_sel ? lp_sample : hp_sample;   // R23
		end else if (!hook_reg) begin
			load_next = 1'b1;
			if (rpos_reg)
				word_next = SAMP_POS_FS;
			else if (rneg_reg && ctrl_reg.fw_ring)
				word_next = SAMP_NEG_FS;
			else
				word_next = ctrl_reg.fw_ring ? SAMP_FW_IDLE : SAMP_NEG_FS;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= lemc_ctrl_t'(CTRL_RST);
			rov_reg  <= 1'b0;
			btd_reg  <= 1'b0;
			rdy_reg  <= 1'b0;
			err_reg  <= 1'b0;
			rd_reg   <= 32'h00000000;
			term_reg <= TERM_NORMAL;
			cnt_reg  <= '0;
			term800_reg <= 1'b0;
			restore_reg <= 1'b0;
			rpos_reg <= 1'b0;
			rneg_reg <= 1'b0;
			hook_reg <= 1'b0;
			hp_reg   <= 1'b0;
			lp_reg   <= 1'b0;
			rcr_reg  <= 1'b0;
			att_reg  <= 3'h0;
			word_reg <= 16'h0000;
			load_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			rov_reg  <= rov_next;
			btd_reg  <= btd_next;
			rdy_reg  <= rdy_next;
			err_reg  <= err_next;
			rd_reg   <= rd_next;
			term_reg <= term_next;
			cnt_reg  <= cnt_next;
			// Registered decodes so the termination pins come straight from flops
			term800_reg <= (term_next == TERM_800);             // R4
			restore_reg <= (term_next == TERM_RESTORE);         // R7
			rpos_reg <= line_in.ring_pos;                       // R24
			rneg_reg <= line_in.ring_neg;                       // R24
			hook_reg <= line_in.offhook_req;                    // R10
			hp_reg   <= ctrl_next.onhook_monitor_enable && !ctrl_next.lp_sel;   // R11
			lp_reg   <= ctrl_next.onhook_monitor_enable && ctrl_next.lp_sel;    // R12
			rcr_reg  <= ctrl_next.ring_cpl_rst;                // R16
			// Gain codes above the last step hold the deepest attenuation
			att_reg  <= (ctrl_next.onhook_monitor_enable && ctrl_next.lp_sel) ?
				((ctrl_next.rx_gain > ATTEN_MAX) ? ATTEN_MAX : ctrl_next.rx_gain) :
				3'h0;                                           // R14
			word_reg <= word_next;
			load_reg <= load_next;
		end
	end

	assign prdata              = rd_reg;
	assign pready              = rdy_reg;
	assign pslverr             = err_reg;
	assign hookswitch          = hook_reg;
	assign term_800ohm         = term800_reg;
	assign dc_restore          = restore_reg;
	assign hp_adc_en           = hp_reg;
	assign lp_adc_en           = lp_reg;
	assign lp_atten            = att_reg;
	assign ring_coupling_reset = rcr_reg;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && !pready ##1 psel && penable && pready;
	endsequence

	a_btd_set_event: assert property (ctrl_reg.billing_tone_enable && line_in.supply_depleted |=> btd_reg) // R4
		else $error("detect flag missed depletion");
	a_rov_set_event: assert property (ctrl_reg.billing_tone_enable && ovl_level |=> rov_reg) // R3
		else $error("overload flag missed level");
	a_flags_need_enable: assert property ($rose(btd_reg) || $rose(rov_reg) |-> $past(ctrl_reg.billing_tone_enable)) // R1
		else $error("flag set with detection disabled");
	a_flag_write_one: assert property (wr_stat && pwdata[STAT_BTD] && btd_reg |=> btd_reg) // R25
		else $error("writing one cleared detect flag");
	a_flag_sticky: assert property (rov_reg && !wr_stat |=> rov_reg) // R5
		else $error("overload flag dropped without write");
	a_term_follow: assert property (term_reg == TERM_NORMAL && ctrl_reg.billing_tone_enable
			&& line_in.supply_depleted |=> term_800ohm) // R4
		else $error("termination did not switch to 800 ohm");
	a_restore_slow: assert property (term_800ohm && !ctrl_reg.billing_tone_enable
			|=> dc_restore [*8]) // R7
		else $error("termination restored at once");
	a_lp_select: assert property (ctrl_reg.onhook_monitor_enable && ctrl_reg.lp_sel |-> lp_adc_en && !hp_adc_en) // R12
		else $error("low-power converter not chosen");
	a_hp_select: assert property (ctrl_reg.onhook_monitor_enable && !ctrl_reg.lp_sel |-> hp_adc_en) // R11
		else $error("monitor converter not started");
	a_hook_held: assert property (term_800ohm && line_in.offhook_req |=> hookswitch) // R10
		else $error("hookswitch dropped during billing event");
	a_apb_wait_one: assert property (s_setup |=> s_access)
		else $error("apb access did not complete in two cycles");

	// Clears, converter choice and pin copies
	a_rov_write_clear: assert property (wr_stat && !pwdata[STAT_ROV]
			&& !(ctrl_reg.billing_tone_enable && ovl_level) |=> !rov_reg) // R5
		else $error("overload flag not cleared by written zero");
	a_btd_write_clear: assert property (wr_stat && !pwdata[STAT_BTD]
			&& !(ctrl_reg.billing_tone_enable && line_in.supply_depleted) |=> !btd_reg) // R5
		else $error("detect flag not cleared by written zero");
	a_conv_exclusive: assert property (!(hp_adc_en && lp_adc_en)) // R12
		else $error("both converters enabled");
	a_atten_range: assert property (lp_atten <= ATTEN_MAX) // R14
		else $error("attenuation step out of range");
	a_rcr_follow: assert property (ctrl_reg.ring_cpl_rst |-> ring_coupling_reset) // R16
		else $error("ring coupling reset not driven");
	a_ring_pos_flag: assert property (line_in.ring_pos |=> rpos_reg) // R24
		else $error("positive ring flag missed");
	a_ring_neg_flag: assert property (line_in.ring_neg |=> rneg_reg) // R24
		else $error("negative ring flag missed");
	a_hook_follow: assert property (line_in.offhook_req |=> hookswitch) // R10
		else $error("hookswitch did not follow request");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error response without ready");
endmodule : lemc_top
`default_nettype wire

//--- hdl/lemc_pkg.sv
// Purpose: Shared constants and types for the line event monitor control block
// Assumes: 50 MHz ref_clk, 16-bit signed line samples, 32-bit APB registers
// Notes:   Field positions refer to the control and status words
package lemc_pkg;
	localparam int unsigned CLK_HZ      = 50_000_000;
	localparam int unsigned RESTORE_MS  = 1000;
	localparam int unsigned RESTORE_CYC = CLK_HZ / 1000 * RESTORE_MS;
	localparam int unsigned RESTORE_W   = 26;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;

	localparam int CTRL_BTE   = 0;
	localparam int CTRL_ONHOOK_MONITOR_ENABLE  = 1;
	localparam int CTRL_LPSEL = 2;
	localparam int CTRL_RCRST = 3;
	localparam int CTRL_FWR   = 4;
	localparam int CTRL_GAIN  = 5;
	localparam int CTRL_W     = 8;
	localparam logic [7:0] CTRL_RST = 8'h00;

	localparam int STAT_ROV  = 0;
	localparam int STAT_BTD  = 1;
	localparam int STAT_OVL  = 2;
	localparam int STAT_RPOS = 3;
	localparam int STAT_RNEG = 4;
	localparam int STAT_T800 = 5;
	localparam int STAT_RAMP = 6;

	// Line full scale in millivolts peak; the overload point is 1.1 V peak
	localparam int unsigned FS_MV   = 2200;
	localparam int unsigned OVL_MV  = 1100;
	localparam logic [15:0] OVL_CODE = 16'(OVL_MV * 32767 / FS_MV);
	localparam int unsigned LPF_SHIFT = 2;

	localparam logic [15:0] SAMP_NEG_FS  = 16'h8000;
	localparam logic [15:0] SAMP_POS_FS  = 16'h7fff;
	localparam logic [15:0] SAMP_FW_IDLE = 16'h04cc;
	localparam logic [2:0]  ATTEN_MAX    = 3'h4;
	localparam int unsigned SER_W        = 16;

	typedef struct packed {
		logic [2:0] rx_gain;
		logic       fw_ring;
		logic       ring_cpl_rst;
		logic       lp_sel;
		logic       onhook_monitor_enable;
		logic       billing_tone_enable;
	} lemc_ctrl_t;

	typedef struct packed {
		logic supply_depleted;
		logic ring_pos;
		logic ring_neg;
		logic offhook_req;
	} lemc_line_t;

	typedef enum logic [1:0] {TERM_NORMAL, TERM_800, TERM_RESTORE} lemc_term_t;
endpackage : lemc_pkg

//--- hdl/lemc_rx_filter.sv
// Purpose: Receive low-pass filter and peak overload comparator
// Assumes: Signed 16-bit samples with a one-cycle valid strobe
// Notes:   First-order IIR; small tones are smoothed, large peaks are flagged
`timescale 1ns/1ps
`default_nettype none
module lemc_rx_filter
	import lemc_pkg::*;
(
	input  wire logic              ref_clk,   // System clock
	input  wire logic              rst_n,     // Async reset, active low
	input  wire logic signed [15:0] x,        // Raw line sample
	input  wire logic              x_valid,   // Sample strobe
	output logic signed [15:0]     y,         // Filtered sample
	output logic                   y_valid,   // Filtered strobe
	output logic                   over       // Last sample above 1.1 V peak
);
	logic signed [15:0] y_reg, y_next;
	logic               v_reg, v_next, o_reg, o_next;
	logic        [15:0] mag;
	logic signed [16:0] diff;

	always_comb begin
		mag    = x[15] ? 16'(-x) : 16'(x);
		// Difference kept at 17 bits so a full-scale step cannot wrap
		diff   = 17'(x) - 17'(y_reg);
		y_next = y_reg;
		o_next = o_reg;
		v_next = x_valid;
		if (x_valid) begin
			y_next = 16'(y_reg + (diff >>> LPF_SHIFT));     // R2
			o_next = (mag > OVL_CODE);                       // R3
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			y_reg <= '0;
			v_reg <= 1'b0;
			o_reg <= 1'b0;
		end else begin
			y_reg <= y_next;
			v_reg <= v_next;
			o_reg <= o_next;
		end
	end

	assign y       = y_reg;
	assign y_valid = v_reg;
	assign over    = o_reg;
endmodule : lemc_rx_filter
`default_nettype wire

//--- hdl/lemc_ser.sv
// Purpose: Serialises 16-bit monitor words MSB first toward the system side
// Assumes: A new word is taken when the shifter is idle or on its last bit
// Notes:   Words arriving while busy are dropped; the link is faster than samples
`timescale 1ns/1ps
`default_nettype none
module lemc_ser
	import lemc_pkg::*;
(
	input  wire logic              ref_clk,  // System clock
	input  wire logic              rst_n,    // Async reset, active low
	input  wire logic [SER_W-1:0]  word,     // Word to send
	input  wire logic              load,     // Word strobe
	output logic                   sdata,    // Serial bit
	output logic                   frame     // High on the MSB bit
);
	logic [SER_W-1:0] sh_reg, sh_next;
	logic [4:0]       cnt_reg, cnt_next;
	logic             f_reg, f_next;

	always_comb begin
		sh_next  = sh_reg;
		cnt_next = cnt_reg;
		f_next   = 1'b0;
		if (cnt_reg != 5'h00) begin
			sh_next  = {sh_reg[SER_W-2:0], 1'b0};
			cnt_next = cnt_reg - 5'h01;
		end
		if (load && cnt_reg <= 5'h01) begin
			sh_next  = word;
			cnt_next = 5'(SER_W);
			f_next   = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_reg  <= '0;
			cnt_reg <= 5'h00;
			f_reg   <= 1'b0;
		end else begin
			sh_reg  <= sh_next;
			cnt_reg <= cnt_next;
			f_reg   <= f_next;
		end
	end

	assign sdata = sh_reg[SER_W-1];
	assign frame = f_reg;
endmodule : lemc_ser
`default_nettype wire

//--- tb/lemc_sys_model.sv
// Purpose: System-side receiver that rebuilds monitor words from the serial line
// Assumes: Words arrive MSB first, frame marks the MSB bit
// Notes:   A frame in mid-word restarts capture, as a real receiver would resync
`timescale 1ns/1ps
`default_nettype none
module lemc_sys_model (
	input  wire logic   ref_clk,    // System clock
	input  wire logic   rst_n,      // Async reset, active low
	input  wire logic   sdata,      // Serial sample bit
	input  wire logic   frame,      // Word start marker
	output logic [15:0] word,       // Last complete word
	output logic        word_valid  // One-cycle strobe per word
);
	logic [15:0] sh;
	int          cnt;
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sh <= '0;
			cnt <= 0;
			word <= '0;
			word_valid <= 1'b0;
		end else begin
			word_valid <= 1'b0;
			if (frame) begin
				sh <= {15'h0, sdata};
				cnt <= 1;
			end else if (cnt > 0) begin
				sh <= {sh[14:0], sdata};
				cnt <= (cnt == 15) ? 0 : cnt + 1;
				if (cnt == 15) begin
					word <= {sh[14:0], sdata};
					word_valid <= 1'b1;
				end
			end
		end
	end
endmodule : lemc_sys_model
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the line event monitor control block
// Assumes: Restore ramp shortened to RST_CYC cycles
// Notes:   Expected values come from a small integer model kept here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lemc_pkg::*;
	localparam int RST_CYC = 20;
	logic               ref_clk = 1'b0;
	logic               rst_n;
	logic [7:0]         paddr;
	logic               psel, penable, pwrite;
	logic [31:0]        pwdata, prdata, r;
	logic               pready, pslverr, e;
	lemc_line_t         line_in;
	logic signed [15:0] rx_sample, rx_filtered;
	logic               rx_valid, rx_filt_valid, mon_valid;
	logic [15:0]        hp_sample, lp_sample, sys_word;
	logic               hookswitch, term_800ohm, dc_restore, hp_adc_en, lp_adc_en;
	logic [2:0]         lp_atten;
	logic               ring_coupling_reset, serial_sample_out, sample_frame, sys_valid;
	logic [15:0]        ring_word [3] = '{SAMP_POS_FS, SAMP_NEG_FS, SAMP_FW_IDLE};
	int                 failures = 0;
	int                 cmp_count = 0;
	int                 m_ctrl, m_stat, n, m_y;

	always #10 ref_clk = ~ref_clk;

	lemc_top #(.RESTORE_CYCLES(RST_CYC)) lemc_top_inst (
		.ref_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .line_in, .rx_sample, .rx_valid, .hp_sample, .lp_sample, .mon_valid,
		.hookswitch, .term_800ohm, .dc_restore, .hp_adc_en, .lp_adc_en, .lp_atten,
		.ring_coupling_reset, .rx_filtered, .rx_filt_valid, .serial_sample_out,
		.sample_frame
	);
	lemc_sys_model lemc_sys_model_inst (
		.ref_clk, .rst_n, .sdata(serial_sample_out), .frame(sample_frame),
		.word(sys_word), .word_valid(sys_valid)
	);

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : tick

	// Held until pready is seen at an edge; read data is taken at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'h1, {31'h0, pready});
		// One idle edge so a following call never re-raises psel in this step
		@(posedge ref_clk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, '0);
		chk(what, exp, r);
		chk("pslverr", 32'h0, {31'h0, e});
	endtask : rd

	task automatic chk_ser(input logic [15:0] exp);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (sys_valid !== 1'b1 && n < 60);
		chk("serial valid", 32'h1, {31'h0, sys_valid});
		chk("serial word", {16'h0, exp}, {16'h0, sys_word});
	endtask : chk_ser

	task automatic mon_pulse;
		hp_sample <= 16'($urandom);
		lp_sample <= 16'($urandom);
		mon_valid <= 1'b1;
		@(posedge ref_clk);
		mon_valid <= 1'b0;
	endtask : mon_pulse

	// Reference low-pass: y += (x - y) >>> shift, arithmetic on wide integers
	task automatic pulse_rx(input logic [15:0] s);
		rx_sample <= s;
		rx_valid <= 1'b1;
		m_y = m_y + (($signed(s) - m_y) >>> LPF_SHIFT);
		@(posedge ref_clk);
		rx_valid <= 1'b0;
		@(negedge ref_clk);
		chk("rx_filt_valid", 32'h1, {31'h0, rx_filt_valid});
		chk("rx_filtered", 32'(m_y), 32'(rx_filtered));
		tick(4);
	endtask : pulse_rx

	task automatic final_report;
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	initial begin
		repeat (20000) @(posedge ref_clk);
		failures++;
		final_report();
	end

	initial begin
		void'($urandom(55984));
		rst_n = 1'b0;
		{paddr, psel, penable, pwrite, pwdata} = '0;
		line_in = '0;
		{rx_sample, rx_valid, hp_sample, lp_sample, mon_valid} = '0;
		tick(4);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(ADDR_CTRL, 32'h0, "control reset");
		rd(ADDR_STAT, 32'h0, "status reset");
		apb(1'b0, 8'h08, '0);
		chk("unmapped err", 32'h1, {31'h0, e});
		// Every gain code, alternating converters; odd codes pick the low-power one
		for (int g = 0; g < 8; g++) begin
			m_ctrl = (g << CTRL_GAIN) | ((g & 1) << CTRL_LPSEL) | (1 << CTRL_ONHOOK_MONITOR_ENABLE);
			apb(1'b1, ADDR_CTRL, m_ctrl & ~(1 << CTRL_ONHOOK_MONITOR_ENABLE));
			apb(1'b1, ADDR_CTRL, m_ctrl);
			tick(20);
			chk("hp_adc_en", 32'((g & 1) == 0), {31'h0, hp_adc_en});
			chk("lp_adc_en", 32'(g & 1), {31'h0, lp_adc_en});
			chk("lp_atten", (g & 1) ? ((g > 4) ? 4 : g) : 0, {29'h0, lp_atten});
			rd(ADDR_CTRL, m_ctrl, "control readback");
			mon_pulse();
			chk_ser((g & 1) ? lp_sample : hp_sample);
		end
		// Ring states with monitor off: positive, negative, full-wave idle
		for (int k = 0; k < 3; k++) begin
			line_in <= lemc_line_t'({1'b0, k == 0, k == 1, 1'b0});
			apb(1'b1, ADDR_CTRL, ((k == 2) << CTRL_FWR) | (1 << CTRL_RCRST));
			tick(3);
			chk("ring_coupling_reset", 32'h1, {31'h0, ring_coupling_reset});
			rd(ADDR_STAT, ((k == 0) << STAT_RPOS) | ((k == 1) << STAT_RNEG), "ring");
			tick(40);
			chk_ser(ring_word[k]);
		end
		// Caller ID capture: coupling reset, then select, then monitor enable
		apb(1'b1, ADDR_CTRL, 1 << CTRL_RCRST);
		apb(1'b1, ADDR_CTRL, (1 << CTRL_RCRST) | (1 << CTRL_LPSEL));
		apb(1'b1, ADDR_CTRL, (1 << CTRL_RCRST) | (1 << CTRL_LPSEL) | (1 << CTRL_ONHOOK_MONITOR_ENABLE));
		tick(20);
		chk("lp_adc_en", 32'h1, {31'h0, lp_adc_en});
		mon_pulse();
		chk_ser(lp_sample);
		chk("ring_coupling_reset", 32'h1, {31'h0, ring_coupling_reset});
		apb(1'b1, ADDR_CTRL, 32'h0);
		line_in <= lemc_line_t'(4'b1001);
		pulse_rx(OVL_CODE + 16'h0100);
		apb(1'b0, ADDR_STAT, '0);
		chk("flags while disabled", 32'h0, r & 32'h23);
		line_in <= lemc_line_t'(4'b0001);
		pulse_rx(16'h0010);
		apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_BTE);
		m_stat = 0;
		pulse_rx(OVL_CODE - 16'($urandom % 256));
		rd(ADDR_STAT, m_stat, "small tone");
		pulse_rx(OVL_CODE + 16'h0001 + 16'($urandom % 256));
		m_stat = (1 << STAT_ROV) | (1 << STAT_OVL);
		rd(ADDR_STAT, m_stat, "overload");
		pulse_rx(16'h0010);
		m_stat = 1 << STAT_ROV;
		rd(ADDR_STAT, m_stat, "level drops, flag holds");
		line_in <= lemc_line_t'(4'b1001);
		tick(4);
		m_stat |= (1 << STAT_BTD) | (1 << STAT_T800);
		rd(ADDR_STAT, m_stat, "detect");
		chk("term_800ohm", 32'h1, {31'h0, term_800ohm});
		line_in <= lemc_line_t'(4'b0001);
		apb(1'b1, ADDR_STAT, 32'h3);
		rd(ADDR_STAT, m_stat, "write ones");
		apb(1'b1, ADDR_STAT, 32'h0);
		m_stat &= ~32'h3;
		rd(ADDR_STAT, m_stat, "write zero");
		apb(1'b1, ADDR_CTRL, 32'h0);
		m_stat = 0;
		for (int c = 0; c < 60; c++) begin
			@(posedge ref_clk);
			m_stat += (dc_restore === 1'b1);
		end
		chk("restore cycles", RST_CYC, m_stat);
		rd(ADDR_STAT, 32'h0, "after restore");
		chk("term after restore", 32'h0, {31'h0, term_800ohm});
		chk("hookswitch", 32'h1, {31'h0, hookswitch});
		final_report();
	end
endmodule : tb_top
`default_nettype wire
